// File: hdl/host_serial_pin_sharing.sv
`timescale 1ns/100ps
module host_serial_pin_sharing
   import pin_share_pkg::*;
(
   // Clock and reset.
   input  wire logic                                     CLK,
   input  wire logic                                     RESET_N,
   // Function selects, one per pin, high selects the peripheral; port B goes to the host port only when all its bits are high.
   input  wire logic [pin_share_pkg::PORT_B_W-1:0]       PORT_B_FUNC,
   input  wire logic [pin_share_pkg::PORT_C_W-1:0]       PORT_C_FUNC,
   // General purpose direction and output values.
   input  wire logic [pin_share_pkg::PORT_B_W-1:0]       PORT_B_DIR,
   input  wire logic [pin_share_pkg::PORT_B_W-1:0]       PORT_B_OUT,
   input  wire logic [pin_share_pkg::PORT_C_W-1:0]       PORT_C_DIR,
   input  wire logic [pin_share_pkg::PORT_C_W-1:0]       PORT_C_OUT,
   output logic      [pin_share_pkg::PORT_B_W-1:0]       PORT_B_IN,
   output logic      [pin_share_pkg::PORT_C_W-1:0]       PORT_C_IN,
   // Core side of the host port.
   input  wire logic [pin_share_pkg::HOST_DATA_W-1:0]    HOST_READ_DATA,
   input  wire logic                                     HOST_REQUEST_ASSERT,
   output logic      [pin_share_pkg::HOST_DATA_W-1:0]    HOST_WRITE_DATA,
   output logic      [pin_share_pkg::HOST_SEL_W-1:0]     HOST_WRITE_SEL,
   output logic                                          HOST_WRITE_STROBE,
   output logic                                          HOST_ACK_LEVEL,
   // Core side of the serial units.
   input  wire logic                                     ASYNC_CLK_OUT_EN,
   input  wire logic                                     ASYNC_CLK_OUT,
   input  wire logic [pin_share_pkg::ASYNC_BITS-1:0]     ASYNC_TX_WORD,
   input  wire logic                                     ASYNC_TX_LOAD,
   output logic      [pin_share_pkg::ASYNC_BITS-1:0]     ASYNC_RX_SHIFT,
   input  wire logic                                     SYNC_CLK_OUT_EN,
   input  wire logic                                     SYNC_CLK_OUT,
   input  wire logic [2:0]                               SYNC_CTRL_OUT,
   input  wire logic [2:0]                               SYNC_CTRL_OUT_EN,
   input  wire logic [pin_share_pkg::SYNC_BITS-1:0]      SYNC_TX_WORD,
   input  wire logic                                     SYNC_TX_LOAD,
   output logic      [pin_share_pkg::SYNC_BITS-1:0]      SYNC_RX_SHIFT,
   output logic      [2:0]                               SYNC_CTRL_IN,
   // Port B pins: output enables are low while driving.
   input  wire logic [pin_share_pkg::PORT_B_W-1:0]       PB_PIN_IN,
   output logic      [pin_share_pkg::PORT_B_W-1:0]       PB_PIN_OUT,
   output logic      [pin_share_pkg::PORT_B_W-1:0]       PB_PIN_OE_N,
   // Port C pins: output enables are low while driving.
   input  wire logic [pin_share_pkg::PORT_C_W-1:0]       PC_PIN_IN,
   output logic      [pin_share_pkg::PORT_C_W-1:0]       PC_PIN_OUT,
   output logic      [pin_share_pkg::PORT_C_W-1:0]       PC_PIN_OE_N
);
   import pin_share_pkg::*;

   typedef struct packed {
      logic [PORT_B_W-1:0]    b_meta;
      logic [PORT_B_W-1:0]    b_sync;
      logic [PORT_C_W-1:0]    c_meta;
      logic [PORT_C_W-1:0]    c_sync;
      logic                   enable_n_prev;
      logic [HOST_DATA_W-1:0] wr_data;
      logic [HOST_SEL_W-1:0]  wr_sel;
      logic                   wr_strobe;
      logic                   aclk_prev;
      logic [ASYNC_BITS-1:0]  arx;
      logic [ASYNC_BITS-1:0]  atx;
      logic                   atx_bit;
      logic                   sclk_prev;
      logic [SYNC_BITS-1:0]   srx;
      logic [SYNC_BITS-1:0]   stx;
      logic                   stx_bit;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic host_mode;
   logic host_enable_n;
   logic host_rnw;
   logic host_read_active;
   logic aclk_level;
   logic sclk_level;

   // The host port counts as one function; it is only in use when every pin is handed over.
   assign host_mode        = &PORT_B_FUNC;
   assign host_enable_n    = st_r.b_sync[PB_ENABLE];
   assign host_rnw         = st_r.b_sync[PB_RNW];
   assign host_read_active = host_mode && !host_enable_n && host_rnw;
   assign aclk_level       = ASYNC_CLK_OUT_EN ? ASYNC_CLK_OUT : st_r.c_sync[PC_ASYNC_CLK];
   assign sclk_level       = SYNC_CLK_OUT_EN ? SYNC_CLK_OUT : st_r.c_sync[PC_SYNC_CLK];

   always_comb begin
      st_nxt               = st_r;
      st_nxt.b_meta        = PB_PIN_IN;
      st_nxt.b_sync        = st_r.b_meta;
      st_nxt.c_meta        = PC_PIN_IN;
      st_nxt.c_sync        = st_r.c_meta;
      st_nxt.wr_strobe     = 1'b0;
      st_nxt.enable_n_prev = host_enable_n;
      // Only a low-to-high step of the synchronized enable counts, so an enable held high cannot
      // store a second copy of the byte.
      if (host_mode && !st_r.enable_n_prev && host_enable_n && !st_r.b_sync[PB_RNW]) begin
         st_nxt.wr_data   = st_r.b_sync[PB_SEL_LSB-1:PB_DATA_LSB];
         st_nxt.wr_sel    = st_r.b_sync[PB_RNW-1:PB_SEL_LSB];
         st_nxt.wr_strobe = 1'b1;
      end
      st_nxt.aclk_prev = aclk_level;
      if (PORT_C_FUNC[PC_ASYNC_RX] && aclk_level && !st_r.aclk_prev) begin
         st_nxt.arx = {st_r.c_sync[PC_ASYNC_RX], st_r.arx[ASYNC_BITS-1:1]};
      end
      if (ASYNC_TX_LOAD) begin
         st_nxt.atx = ASYNC_TX_WORD;
      end else if (!aclk_level && st_r.aclk_prev) begin
         st_nxt.atx_bit = st_r.atx[0];
         st_nxt.atx     = {1'b1, st_r.atx[ASYNC_BITS-1:1]};
      end
      st_nxt.sclk_prev = sclk_level;
      if (PORT_C_FUNC[PC_SYNC_RX] && sclk_level && !st_r.sclk_prev) begin
         st_nxt.srx = {st_r.srx[SYNC_BITS-2:0], st_r.c_sync[PC_SYNC_RX]};
      end
      if (SYNC_TX_LOAD) begin
         st_nxt.stx = SYNC_TX_WORD;
      end else if (!sclk_level && st_r.sclk_prev) begin
         st_nxt.stx_bit = st_r.stx[SYNC_BITS-1];
         st_nxt.stx     = {st_r.stx[SYNC_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Port B pin drivers.
   always_comb begin
      PB_PIN_OUT  = PORT_B_OUT;
      PB_PIN_OE_N = ~PORT_B_DIR;
      if (host_mode) begin
         PB_PIN_OUT  = '0;
         PB_PIN_OE_N = '1;
         if (host_read_active) begin
            PB_PIN_OUT[PB_SEL_LSB-1:PB_DATA_LSB]  = HOST_READ_DATA;
            PB_PIN_OE_N[PB_SEL_LSB-1:PB_DATA_LSB] = '0;
         end
         // Open drain: only the low level is driven, the pull-up gives the high.
         PB_PIN_OE_N[PB_REQUEST] = !HOST_REQUEST_ASSERT;
      end
      if (!RESET_N) begin
         PB_PIN_OE_N = '1;
      end
   end

   // Port C pin drivers; each pin chooses its function on its own.
   always_comb begin
      PC_PIN_OUT  = PORT_C_OUT;
      PC_PIN_OE_N = ~PORT_C_DIR;
      if (PORT_C_FUNC[PC_ASYNC_RX]) begin
         PC_PIN_OE_N[PC_ASYNC_RX] = 1'b1;
      end
      if (PORT_C_FUNC[PC_ASYNC_TX]) begin
         PC_PIN_OUT[PC_ASYNC_TX]  = st_r.atx_bit;
         PC_PIN_OE_N[PC_ASYNC_TX] = 1'b0;
      end
      if (PORT_C_FUNC[PC_ASYNC_CLK]) begin
         PC_PIN_OUT[PC_ASYNC_CLK]  = ASYNC_CLK_OUT;
         PC_PIN_OE_N[PC_ASYNC_CLK] = !ASYNC_CLK_OUT_EN;
      end
      for (int i = 0; i < 3; i++) begin
         if (PORT_C_FUNC[PC_SYNC_C0+i]) begin
            PC_PIN_OUT[PC_SYNC_C0+i]  = SYNC_CTRL_OUT[i];
            PC_PIN_OE_N[PC_SYNC_C0+i] = !SYNC_CTRL_OUT_EN[i];
         end
      end
      if (PORT_C_FUNC[PC_SYNC_CLK]) begin
         PC_PIN_OUT[PC_SYNC_CLK]  = SYNC_CLK_OUT;
         PC_PIN_OE_N[PC_SYNC_CLK] = !SYNC_CLK_OUT_EN;
      end
      if (PORT_C_FUNC[PC_SYNC_RX]) begin
         PC_PIN_OE_N[PC_SYNC_RX] = 1'b1;
      end
      if (PORT_C_FUNC[PC_SYNC_TX]) begin
         PC_PIN_OUT[PC_SYNC_TX]  = st_r.stx_bit;
         PC_PIN_OE_N[PC_SYNC_TX] = 1'b0;
      end
      if (!RESET_N) begin
         PC_PIN_OE_N = '1;
      end
   end

   assign PORT_B_IN         = st_r.b_sync;
   assign PORT_C_IN         = st_r.c_sync;
   assign HOST_WRITE_DATA   = st_r.wr_data;
   assign HOST_WRITE_SEL    = st_r.wr_sel;
   assign HOST_WRITE_STROBE = st_r.wr_strobe;
   // The acknowledge is handed over as a synchronized level, inverted and gated by host_mode; the core decides DMA or interrupt use.
   assign HOST_ACK_LEVEL    = host_mode && !st_r.b_sync[PB_ACK];
   assign ASYNC_RX_SHIFT    = st_r.arx;
   assign SYNC_RX_SHIFT     = st_r.srx;
   assign SYNC_CTRL_IN      = st_r.c_sync[PC_SYNC_C0+2:PC_SYNC_C0];

   AST_BUS_INPUT_UNLESS_READ: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode && !host_read_active |-> PB_PIN_OE_N[7:0] == 8'hff)
      else $error("host data bus driven outside a read");
   AST_READ_DRIVES_DATA: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_read_active |-> PB_PIN_OE_N[7:0] == 8'h00 && PB_PIN_OUT[7:0] == HOST_READ_DATA)
      else $error("read data not driven");
   AST_WRITE_CAPTURE: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode && !st_r.enable_n_prev && host_enable_n && !host_rnw
      |=> HOST_WRITE_STROBE && HOST_WRITE_DATA == $past(st_r.b_sync[7:0]))
      else $error("write byte not captured at enable release");
   AST_ONE_STROBE: assert property (@(posedge CLK) disable iff (!RESET_N)
      HOST_WRITE_STROBE |=> !HOST_WRITE_STROBE)
      else $error("write captured twice");
   AST_GPIO_B: assert property (@(posedge CLK) disable iff (!RESET_N)
      !host_mode |-> PB_PIN_OE_N == ~PORT_B_DIR && PB_PIN_OUT == PORT_B_OUT)
      else $error("port B not general purpose");
   AST_REQ_OPEN_DRAIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode |-> PB_PIN_OUT[PB_REQUEST] == 1'b0)
      else $error("request drives high in host mode");
   AST_ASYNC_RX_RISE: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[0] && aclk_level && !st_r.aclk_prev
      |=> ASYNC_RX_SHIFT[7] == $past(st_r.c_sync[0]))
      else $error("receive bit not taken on rising clock");
   AST_ASYNC_TX_STABLE: assert property (@(posedge CLK) disable iff (!RESET_N)
      aclk_level && st_r.aclk_prev |=> $stable(st_r.atx_bit))
      else $error("transmit line moved while clock high");
   AST_SYNC_TX_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[8] |-> PC_PIN_OE_N[8] == 1'b0 && PC_PIN_OUT[8] == st_r.stx_bit)
      else $error("sync transmit pin not driven");

   // The reset checks carry no disable, because the reset state is what they guard.
   AST_PB_RESET_RELEASED: assert property (@(posedge CLK)
      !RESET_N |-> PB_PIN_OE_N == 15'h7fff)
      else $error("port B driven during reset");
   AST_PC_RESET_RELEASED: assert property (@(posedge CLK)
      !RESET_N |-> PC_PIN_OE_N == 9'h1ff)
      else $error("port C driven during reset");
   AST_GPIO_C: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC == 9'h000 |-> PC_PIN_OE_N == ~PORT_C_DIR && PC_PIN_OUT == PORT_C_OUT)
      else $error("port C not general purpose");
   AST_HOST_CTRL_INPUT: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode |-> PB_PIN_OE_N[12:8] == 5'h1f && PB_PIN_OE_N[14])
      else $error("host control line driven in host mode");
   AST_REQ_PULLS_LOW: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode |-> PB_PIN_OE_N[PB_REQUEST] == !HOST_REQUEST_ASSERT)
      else $error("request pin does not follow the core request");
   AST_ACK_ONLY_HOST: assert property (@(posedge CLK) disable iff (!RESET_N)
      !host_mode |-> !HOST_ACK_LEVEL)
      else $error("acknowledge reported outside host mode");
   AST_NO_WRITE_OUTSIDE_HOST: assert property (@(posedge CLK) disable iff (!RESET_N)
      !host_mode |=> !HOST_WRITE_STROBE)
      else $error("write captured outside host mode");
   AST_WRITE_SEL_CAPTURE: assert property (@(posedge CLK) disable iff (!RESET_N)
      host_mode && !st_r.enable_n_prev && host_enable_n && !host_rnw
      |=> HOST_WRITE_SEL == $past(st_r.b_sync[10:8]))
      else $error("register select not captured with the byte");
   AST_ASYNC_RX_INPUT: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[0] |-> PC_PIN_OE_N[0])
      else $error("async receive pin driven");
   AST_ASYNC_TX_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[1] |-> !PC_PIN_OE_N[1] && PC_PIN_OUT[1] == st_r.atx_bit)
      else $error("async transmit pin not driven");
   AST_ASYNC_TX_FALL: assert property (@(posedge CLK) disable iff (!RESET_N)
      !aclk_level && st_r.aclk_prev && !ASYNC_TX_LOAD |=> st_r.atx_bit == $past(st_r.atx[0]))
      else $error("async transmit bit not moved on falling clock");
   AST_ASYNC_CLK_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[2] |-> PC_PIN_OE_N[2] == !ASYNC_CLK_OUT_EN)
      else $error("async clock pin direction wrong");
   AST_SYNC_CTRL_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[5:3] == 3'b111 |-> PC_PIN_OE_N[5:3] == ~SYNC_CTRL_OUT_EN)
      else $error("sync control pin direction wrong");
   AST_SYNC_CLK_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[6] |-> PC_PIN_OE_N[6] == !SYNC_CLK_OUT_EN)
      else $error("sync clock pin direction wrong");
   AST_SYNC_RX_INPUT: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[7] |-> PC_PIN_OE_N[7])
      else $error("sync receive pin driven");
   AST_SYNC_RX_SHIFT: assert property (@(posedge CLK) disable iff (!RESET_N)
      PORT_C_FUNC[7] && sclk_level && !st_r.sclk_prev
      |=> SYNC_RX_SHIFT[0] == $past(st_r.c_sync[7]))
      else $error("sync receive bit not taken on rising clock");
   AST_SYNC_TX_FALL: assert property (@(posedge CLK) disable iff (!RESET_N)
      !sclk_level && st_r.sclk_prev && !SYNC_TX_LOAD |=> st_r.stx_bit == $past(st_r.stx[7]))
      else $error("sync transmit bit not moved on falling clock");
endmodule // host_serial_pin_sharing

// File: hdl/pin_share_pkg.sv
package pin_share_pkg;
   localparam int HOST_DATA_W  = 8;
   localparam int HOST_SEL_W   = 3;
   localparam int PORT_B_W     = 15;
   localparam int PORT_C_W     = 9;
   localparam logic [14:0] PORT_B_DIR_RESET = 15'h0000;
   localparam logic [8:0]  PORT_C_DIR_RESET = 9'h000;
   localparam logic [14:0] PORT_B_OUT_RESET = 15'h0000;
   localparam logic [8:0]  PORT_C_OUT_RESET = 9'h000;
   localparam logic [7:0]  HOST_BYTE_RESET  = 8'h00;
   localparam int PB_DATA_LSB  = 0;
   localparam int PB_SEL_LSB   = 8;
   localparam int PB_RNW       = 11;
   localparam int PB_ENABLE    = 12;
   localparam int PB_REQUEST   = 13;
   localparam int PB_ACK       = 14;
   localparam int PC_ASYNC_RX  = 0;
   localparam int PC_ASYNC_TX  = 1;
   localparam int PC_ASYNC_CLK = 2;
   localparam int PC_SYNC_C0   = 3;
   localparam int PC_SYNC_CLK  = 6;
   localparam int PC_SYNC_RX   = 7;
   localparam int PC_SYNC_TX   = 8;
   localparam int ASYNC_BITS   = 8;
   localparam int SYNC_BITS    = 8;
endpackage

// File: tb/far_side_model.sv
`timescale 1ns/100ps
// Host processor and serial peers as seen at the shared pins.
module far_side_model (
   // Design drive of the pins.
   input  wire logic [14:0] pb_out,
   input  wire logic [14:0] pb_oe_n,
   input  wire logic [8:0]  pc_out,
   input  wire logic [8:0]  pc_oe_n,
   // Far side levels.
   input  wire logic [14:0] host_pins,
   input  wire logic        host_data_drv,
   input  wire logic [8:0]  pc_drv,
   // Resolved pin levels.
   output logic      [14:0] pb_in,
   output logic      [8:0]  pc_in
);
   always_comb begin
      for (int i = 0; i < 15; i++) begin
         if (!pb_oe_n[i])
            pb_in[i] = pb_out[i];
         else if (i == 13)
            pb_in[i] = 1'b1;
         else if (i < 8 && !host_data_drv)
            pb_in[i] = ~pb_out[i];
         else
            pb_in[i] = host_pins[i];
      end
   end
   // A released serial line shows the far side level, never the design's last value.
   always_comb begin
      for (int i = 0; i < 9; i++)
         pc_in[i] = pc_oe_n[i] ? pc_drv[i] : pc_out[i];
   end
endmodule // far_side_model

// File: tb/host_serial_pin_sharing_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module host_serial_pin_sharing_tb_top;
   import pin_share_pkg::*;
   typedef struct {logic [14:0] bd, bo, hb; logic [8:0] cd, co, cv;} row_s;
   logic CLK, RESET_N, HOST_REQUEST_ASSERT, HOST_WRITE_STROBE, HOST_ACK_LEVEL, hdrv;
   logic ASYNC_CLK_OUT_EN, ASYNC_CLK_OUT, ASYNC_TX_LOAD, SYNC_CLK_OUT_EN, SYNC_CLK_OUT;
   logic SYNC_TX_LOAD;
   logic [14:0] PORT_B_FUNC, PORT_B_DIR, PORT_B_OUT, PORT_B_IN, host_pins;
   logic [14:0] PB_PIN_IN, PB_PIN_OUT, PB_PIN_OE_N;
   logic [8:0] PORT_C_FUNC, PORT_C_DIR, PORT_C_OUT, PORT_C_IN, pc_drv;
   logic [8:0] PC_PIN_IN, PC_PIN_OUT, PC_PIN_OE_N;
   logic [7:0] HOST_READ_DATA, HOST_WRITE_DATA, ASYNC_TX_WORD, ASYNC_RX_SHIFT;
   logic [7:0] SYNC_TX_WORD, SYNC_RX_SHIFT;
   logic [2:0] HOST_WRITE_SEL, SYNC_CTRL_OUT, SYNC_CTRL_OUT_EN, SYNC_CTRL_IN;
   int fail_count = 0, compares = 0, strobes = 0, cyc = 0;
   row_s rows[3] = '{'{15'h2a55, 15'h7fff, 15'h6f0f, 9'h0f3, 9'h1ff, 9'h10c},
                     '{15'h55aa, 15'h0000, 15'h3cc3, 9'h10c, 9'h000, 9'h0f3},
                     '{15'h0000, 15'h0000, 15'h2ff0, 9'h1ff, 9'h0a5, 9'h000}};

   host_serial_pin_sharing DUT (.CLK, .RESET_N, .PORT_B_FUNC, .PORT_C_FUNC, .PORT_B_DIR,
      .PORT_B_OUT, .PORT_C_DIR, .PORT_C_OUT, .PORT_B_IN, .PORT_C_IN, .HOST_READ_DATA,
      .HOST_REQUEST_ASSERT, .HOST_WRITE_DATA, .HOST_WRITE_SEL, .HOST_WRITE_STROBE,
      .HOST_ACK_LEVEL, .ASYNC_CLK_OUT_EN, .ASYNC_CLK_OUT, .ASYNC_TX_WORD, .ASYNC_TX_LOAD,
      .ASYNC_RX_SHIFT, .SYNC_CLK_OUT_EN, .SYNC_CLK_OUT, .SYNC_CTRL_OUT, .SYNC_CTRL_OUT_EN,
      .SYNC_TX_WORD, .SYNC_TX_LOAD, .SYNC_RX_SHIFT, .SYNC_CTRL_IN, .PB_PIN_IN,
      .PB_PIN_OUT, .PB_PIN_OE_N, .PC_PIN_IN, .PC_PIN_OUT, .PC_PIN_OE_N);
   far_side_model peer (.pb_out(PB_PIN_OUT), .pb_oe_n(PB_PIN_OE_N), .pc_out(PC_PIN_OUT),
      .pc_oe_n(PC_PIN_OE_N), .host_pins, .host_data_drv(hdrv), .pc_drv,
      .pb_in(PB_PIN_IN), .pc_in(PC_PIN_IN));

   task automatic stop_test();
      $display("Mismatches %0d, compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Strobes are counted so that a doubled capture of one write shows up.
   always @(posedge CLK) begin
      cyc++;
      if (HOST_WRITE_STROBE === 1'b1)
         strobes++;
      if (cyc == 5000) begin
         fail_count++;
         stop_test();
      end
   end

   // Host write: select and byte are held until enable has fully returned high.
   task automatic hw(input logic [2:0] s, input logic [7:0] d, input int n);
      int c0;
      c0 = strobes;
      @(negedge CLK);
      host_pins[12:0] = {2'b00, s, d};
      hdrv = 1'b1;
      repeat (3) @(negedge CLK);
      host_pins[12] = 1'b1;
      repeat (8) @(negedge CLK);
      host_pins[11] = 1'b1;
      `CHK(strobes - c0, n)
      if (n == 1) begin
         `CHK(HOST_WRITE_DATA, d)
         `CHK(HOST_WRITE_SEL, s)
      end
   endtask

   // The serial clock idles high and only toggles within the frame.
   task automatic ser(input int ck, rx, tx, input logic [7:0] rb, tb, input bit msb);
      int k;
      for (int i = 0; i < 8; i++) begin
         k = msb ? 7 - i : i;
         @(negedge CLK);
         pc_drv[ck] = 1'b0;
         pc_drv[rx] = rb[k];
         repeat (4) @(negedge CLK);
         pc_drv[ck] = 1'b1;
         repeat (4) @(negedge CLK);
         `CHK(PC_PIN_OUT[tx], tb[k])
      end
      repeat (4) @(negedge CLK);
   endtask

   initial begin
      row_s r;
      {RESET_N, HOST_REQUEST_ASSERT, ASYNC_CLK_OUT_EN, ASYNC_CLK_OUT, ASYNC_TX_LOAD} = '0;
      {SYNC_CLK_OUT_EN, SYNC_CLK_OUT, SYNC_TX_LOAD, SYNC_CTRL_OUT, SYNC_CTRL_OUT_EN} = '0;
      {PORT_B_FUNC, PORT_C_FUNC, PORT_B_OUT, PORT_C_OUT, HOST_READ_DATA} = '0;
      {ASYNC_TX_WORD, SYNC_TX_WORD} = '0;
      PORT_B_DIR = '1;
      PORT_C_DIR = '1;
      host_pins = 15'h7fff;
      hdrv = 1'b1;
      pc_drv = '1;
      repeat (4) @(negedge CLK);
      `CHK(PB_PIN_OE_N, 15'h7fff)
      `CHK(PC_PIN_OE_N, 9'h1ff)
      @(negedge CLK);
      RESET_N = 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         {PORT_B_DIR, PORT_B_OUT, host_pins} = {r.bd, r.bo, r.hb};
         {PORT_C_DIR, PORT_C_OUT, pc_drv} = {r.cd, r.co, r.cv};
         repeat (4) @(negedge CLK);
         `CHK(PB_PIN_OE_N, ~r.bd)
         `CHK(PB_PIN_OUT & r.bd, r.bo & r.bd)
         `CHK(PORT_B_IN, (r.bo & r.bd) | (r.hb & ~r.bd))
         `CHK(PC_PIN_OE_N, ~r.cd)
         `CHK(PORT_C_IN, (r.co & r.cd) | (r.cv & ~r.cd))
      end
      host_pins = 15'h7fff;
      hw(3'h5, 8'ha6, 0);
      PORT_B_FUNC = 15'h7fff;
      hw(3'h2, 8'h5b, 1);
      hw(3'h7, 8'hc4, 1);
      hdrv = 1'b0;
      HOST_READ_DATA = 8'h3c;
      `CHK(PB_PIN_OE_N[7:0], 8'hff)
      host_pins[12] = 1'b0;
      repeat (4) @(negedge CLK);
      `CHK(PB_PIN_OE_N[7:0], 8'h00)
      `CHK(PB_PIN_OUT[7:0], 8'h3c)
      host_pins[12] = 1'b1;
      repeat (4) @(negedge CLK);
      `CHK(PB_PIN_OE_N[7:0], 8'hff)
      HOST_REQUEST_ASSERT = 1'b1;
      host_pins[14] = 1'b0;
      repeat (4) @(negedge CLK);
      `CHK({PB_PIN_OE_N[13], PB_PIN_OUT[13]}, 2'b00)
      `CHK(HOST_ACK_LEVEL, 1'b1)
      HOST_REQUEST_ASSERT = 1'b0;
      host_pins[14] = 1'b1;
      repeat (4) @(negedge CLK);
      `CHK(PB_PIN_OE_N[13], 1'b1)
      `CHK(HOST_ACK_LEVEL, 1'b0)
      PORT_C_FUNC = 9'h1ff;
      {ASYNC_TX_WORD, SYNC_TX_WORD, pc_drv} = {8'hb4, 8'h69, 9'h1ef};
      {ASYNC_TX_LOAD, SYNC_TX_LOAD} = 2'b11;
      @(negedge CLK);
      {ASYNC_TX_LOAD, SYNC_TX_LOAD} = 2'b00;
      ser(PC_ASYNC_CLK, PC_ASYNC_RX, PC_ASYNC_TX, 8'h5d, 8'hb4, 1'b0);
      `CHK(ASYNC_RX_SHIFT, 8'h5d)
      ser(PC_SYNC_CLK, PC_SYNC_RX, PC_SYNC_TX, 8'ha3, 8'h69, 1'b1);
      `CHK(SYNC_RX_SHIFT, 8'ha3)
      `CHK(SYNC_CTRL_IN, 3'b101)
      {ASYNC_CLK_OUT_EN, ASYNC_CLK_OUT, SYNC_CLK_OUT_EN} = 3'b111;
      {SYNC_CTRL_OUT_EN, SYNC_CTRL_OUT} = {3'b010, 3'b010};
      @(negedge CLK);
      `CHK({PC_PIN_OE_N[2], PC_PIN_OUT[2]}, 2'b01)
      `CHK({PC_PIN_OE_N[6], PC_PIN_OUT[6]}, 2'b00)
      `CHK({PC_PIN_OE_N[5:3], PC_PIN_OUT[4]}, 4'b1011)
      RESET_N = 1'b0;
      @(negedge CLK);
      `CHK(PB_PIN_OE_N, 15'h7fff)
      `CHK(PC_PIN_OE_N, 9'h1ff)
      `CHK({HOST_WRITE_DATA, PORT_C_IN, ASYNC_RX_SHIFT}, 25'h0000000)
      RESET_N = 1'b1;
      repeat (4) @(negedge CLK);
      `CHK(PC_PIN_OE_N[2], 1'b0)
      `CHK(HOST_WRITE_STROBE, 1'b0)
      stop_test();
   end
endmodule // host_serial_pin_sharing_tb_top
